// [logic/jmip_ilas_fmt.sv]
// assembles one configuration octet of the alignment sequence
`timescale 1ns/1ps
module jmip_ilas_fmt (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  jmip_params_if.user     prm,
  input  wire logic [7:0] did_i,
  input  wire logic [7:0] kfrm_i,
  input  wire logic       scr_i,
  input  wire logic [2:0] lane_i,
  input  wire logic [3:0] idx_i,
  output logic      [7:0] octet_o,
  output logic      [7:0] chk_o
);
  import jmip_pkg::*;
  logic [7:0] next_octet;
  // ==========================================================
  // field sum, count fields in their minus-one encoding
  wire [7:0] fsum = did_i + {5'h00, lane_i} + {7'h00, scr_i}
                  + {5'h00, prm.p.lm1} + {5'h00, prm.p.fm1} + kfrm_i
                  + {5'h00, prm.p.mm1} + {4'h0, prm.p.nm1}
                  + {4'h0, prm.p.npm1} + {5'h00, prm.p.sm1}
                  + {5'h00, SUBV_VAL} + {5'h00, JESDV_VAL};
  // octet selection; zero fields stay zero
  always_comb begin
    next_octet = 8'h00;
    unique case (idx_i)
      OCT_DID: next_octet = did_i;
      OCT_LID: next_octet = {5'h00, lane_i};
      OCT_L:   next_octet = {scr_i, 4'h0, prm.p.lm1};
      OCT_F:   next_octet = {5'h00, prm.p.fm1};
      OCT_K:   next_octet = kfrm_i;
      OCT_M:   next_octet = {5'h00, prm.p.mm1};
      OCT_N:   next_octet = {4'h0, prm.p.nm1};
      OCT_NP:  next_octet = {SUBV_VAL, 1'b0, prm.p.npm1};
      OCT_S:   next_octet = {JESDV_VAL, 2'h0, prm.p.sm1};
      OCT_CHK: next_octet = fsum;
      default: next_octet = 8'h00;
    endcase
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      octet_o <= 8'h00;
      chk_o   <= 8'h00;
    end else begin
      octet_o <= next_octet;
      chk_o   <= fsum;
    end
  end
endmodule // jmip_ilas_fmt

// [logic/jmip_mode_rom.sv]
// mode table: link mode selector to derived transport parameters
`timescale 1ns/1ps
module jmip_mode_rom (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] mode_i,
  jmip_params_if.rom      prm
);
  import jmip_pkg::*;
  jmip_mode_t next_row;
  // ==========================================================
  // table rows: des, L, M, F, S, N, N', CS, R x 8
  always_comb begin
    next_row = '0;
    unique case (mode_i)
      5'h00: next_row = jmip_mk(1, 4, 4, 8, 5, 12, 12, 0, 32);
      5'h01: next_row = jmip_mk(1, 8, 8, 8, 5, 12, 12, 0, 16);
      5'h02: next_row = jmip_mk(0, 4, 4, 8, 5, 12, 12, 0, 32);
      5'h03: next_row = jmip_mk(0, 8, 8, 8, 5, 12, 12, 0, 16);
      5'h05: next_row = jmip_mk(1, 4, 1, 1, 4, 8, 8, 0, 20);
      5'h06: next_row = jmip_mk(1, 8, 1, 1, 8, 8, 8, 0, 10);
      5'h07: next_row = jmip_mk(0, 4, 1, 1, 4, 8, 8, 0, 20);
      5'h08: next_row = jmip_mk(0, 8, 1, 1, 8, 8, 8, 0, 10);
      5'h0a: next_row = jmip_mk(0, 2, 2, 2, 1, 15, 16, 1, 40);
      5'h0b: next_row = jmip_mk(0, 4, 2, 2, 2, 15, 16, 1, 20);
      5'h0c: next_row = jmip_mk(0, 8, 2, 2, 4, 15, 16, 1, 10);
      5'h0d: next_row = jmip_mk(0, 1, 2, 4, 1, 15, 16, 1, 40);
      5'h0e: next_row = jmip_mk(0, 2, 2, 2, 1, 15, 16, 1, 20);
      5'h0f: next_row = jmip_mk(0, 4, 2, 2, 2, 15, 16, 1, 10);
      5'h10: next_row = jmip_mk(0, 8, 2, 2, 4, 15, 16, 1, 5);
      5'h13: next_row = jmip_mk(1, 6, 1, 2, 8, 12, 12, 0, 20);
      5'h14: next_row = jmip_mk(0, 6, 1, 2, 8, 12, 12, 0, 20);
      5'h15: next_row = jmip_mk(1, 2, 1, 2, 2, 15, 16, 1, 40);
      5'h16: next_row = jmip_mk(1, 4, 1, 2, 4, 15, 16, 1, 20);
      5'h17: next_row = jmip_mk(1, 1, 1, 2, 1, 15, 16, 1, 40);
      5'h18: next_row = jmip_mk(1, 2, 1, 2, 2, 15, 16, 1, 20);
      5'h19: next_row = jmip_mk(1, 8, 1, 2, 8, 15, 16, 1, 10);
      5'h1a: next_row = jmip_mk(1, 4, 1, 2, 4, 15, 16, 1, 10);
      5'h1b: next_row = jmip_mk(1, 8, 1, 2, 8, 15, 16, 1, 5);
      default: next_row = '0; // reserved codes read back as invalid
    endcase
  end
  // registered read keeps the lookup off the output timing path
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prm.p <= '0;
    end else begin
      prm.p <= next_row;
    end
  end
endmodule // jmip_mode_rom

// [logic/jmip_params_if.sv]
// carries the derived mode record between the block's own modules
`timescale 1ns/1ps
interface jmip_params_if;
  import jmip_pkg::*;
  jmip_mode_t p;
  modport rom  (output p);
  modport user (input  p);
endinterface // jmip_params_if

// [logic/jmip_pkg.sv]
// shared constants, register map and mode record for the link mode block
package jmip_pkg;
  // ==========================================================
  // register map (word index on the plain register port)
  localparam logic [3:0] REG_MODE   = 4'h0;
  localparam logic [3:0] REG_KFRM   = 4'h1;
  localparam logic [3:0] REG_DID    = 4'h2;
  localparam logic [3:0] REG_CTRL   = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PARAM0 = 4'h5;
  localparam logic [3:0] REG_PARAM1 = 4'h6;
  localparam logic [3:0] REG_CHKSUM = 4'h7;
  // control bit positions
  localparam int CTRL_SCR     = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_LINK    = 3;
  // input mux selections
  localparam logic [1:0] INSEL_A    = 2'h0;
  localparam logic [1:0] INSEL_B    = 2'h1;
  localparam logic [1:0] INSEL_BOTH = 2'h2;
  // reset values
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] KFRM_RST = 8'h1f;
  localparam logic [7:0] DID_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // ==========================================================
  // fixed alignment-sequence values
  localparam logic [2:0] JESDV_VAL = 3'h1;
  localparam logic [2:0] SUBV_VAL  = 3'h1;
  localparam logic [3:0] EMB_FIXED = 4'h1;
  localparam logic [1:0] RATE_DES  = 2'h2;
  localparam logic [1:0] RATE_DUAL = 2'h1;
  // below this lane-rate code (R x 8) the serializer pll is bypassed
  localparam logic [5:0] RATE_X8_BYPASS = 6'h10;
  // octet index inside one lane's configuration block
  localparam logic [3:0] OCT_DID  = 4'h0;
  localparam logic [3:0] OCT_BID  = 4'h1;
  localparam logic [3:0] OCT_LID  = 4'h2;
  localparam logic [3:0] OCT_L    = 4'h3;
  localparam logic [3:0] OCT_F    = 4'h4;
  localparam logic [3:0] OCT_K    = 4'h5;
  localparam logic [3:0] OCT_M    = 4'h6;
  localparam logic [3:0] OCT_N    = 4'h7;
  localparam logic [3:0] OCT_NP   = 4'h8;
  localparam logic [3:0] OCT_S    = 4'h9;
  localparam logic [3:0] OCT_HD   = 4'ha;
  localparam logic [3:0] OCT_RES1 = 4'hb;
  localparam logic [3:0] OCT_RES2 = 4'hc;
  localparam logic [3:0] OCT_CHK  = 4'hd;
  // ==========================================================
  // derived transport parameters, count fields stored minus one
  typedef struct packed {
    logic       valid;
    logic       des;
    logic       enc64;
    logic [2:0] lm1;
    logic [2:0] fm1;
    logic [2:0] mm1;
    logic [3:0] nm1;
    logic       cs;
    logic [3:0] npm1;
    logic [2:0] sm1;
    logic [5:0] rate_x8;
  } jmip_mode_t;
  // builds one table row from the natural figures
  function automatic jmip_mode_t jmip_mk(input int des, input int l, input int m,
                                         input int f, input int s, input int n,
                                         input int np, input int cs, input int r8);
    jmip_mode_t r;
    r.valid   = 1'b1;
    r.des     = 1'(des);
    r.enc64   = 1'b0;
    r.lm1     = 3'(l - 1);
    r.fm1     = 3'(f - 1);
    r.mm1     = 3'(m - 1);
    r.nm1     = 4'(n - 1);
    r.cs      = 1'(cs);
    r.npm1    = 4'(np - 1);
    r.sm1     = 3'(s - 1);
    r.rate_x8 = 6'(r8);
    return r;
  endfunction
endpackage

// [logic/jmip_top.sv]
// link mode configuration and alignment-parameter generator
//
// How it works
// - dual-input mode samples both inputs out of phase
// - dual-input only: single-channel mode plus both inputs
// - dual-input processing looks like plain single-channel
// - all transport parameters follow the mode selector
// - interleave flag one single, zero dual channel
// - R from mode picks pll factor or bypass
// - K from register, ignored in 64B/66B
// - multiblocks per extended multiblock fixed at one
// - alignment sequence only in 8B/10B
// - unused alignment fields all sent as zero
// - control bits per sample always sent zero
// - user device identifier goes into sequence
// - standard revision field always one
// - subclass version field always one
// - scrambler from control register, also reported
// - checksum is field sum modulo 256
// - lane, octet, sample fields come from mode
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module jmip_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              ilas_start_i,
  output logic      [7:0]        ilas_octet_o,
  output logic                   ilas_valid_o,
  output logic      [2:0]        ilas_lane_o,
  output logic                   ilas_last_o,
  output logic                   link_en_o,
  output logic                   scr_en_o,
  output logic                   des_o,
  output logic                   dual_input_o,
  output logic                   dsp_single_o,
  output logic                   adc_b_invert_phase_o,
  output logic      [1:0]        samp_rate_mult_o,
  output logic      [1:0]        ain_sel_o,
  output logic                   enc64_o,
  output logic      [2:0]        lanes_m1_o,
  output logic      [5:0]        rate_x8_o,
  output logic                   pll_bypass_o,
  output logic      [8:0]        frames_per_mf_o,
  output logic      [3:0]        emb_count_o
);
  import jmip_pkg::*;

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 3) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ==========================================================
  // state and storage
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } jmip_state_t;

  jmip_state_t state;
  jmip_state_t next_state;
  logic [4:0]  link_mode_select;
  logic [7:0]  frames_per_multiframe_minus_one;
  logic [7:0]  did_reg;
  logic [7:0]  ctrl_reg;
  logic [2:0]  lane_cnt;
  logic [3:0]  idx_cnt;
  logic        pipe_valid;
  logic        pipe_last;
  logic [2:0]  pipe_lane;
  logic [7:0]  fmt_octet;
  logic [7:0]  fmt_chk;
  logic [7:0]  next_rdata;

  jmip_params_if prm_if ();

  // ==========================================================
  // mode table and octet assembler
  jmip_mode_rom u_rom (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .mode_i (link_mode_select),
    .prm    (prm_if.rom)
  );

  jmip_ilas_fmt u_fmt (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .prm     (prm_if.user),
    .did_i   (did_reg),
    .kfrm_i  (frames_per_multiframe_minus_one),
    .scr_i   (ctrl_reg[CTRL_SCR]),
    .lane_i  (lane_cnt),
    .idx_i   (idx_cnt),
    .octet_o (fmt_octet),
    .chk_o   (fmt_chk)
  );

  // ==========================================================
  // register port decode
  wire [3:0] reg_idx  = 4'(addr_i);
  wire       addr_hi  = (ADDR_W > 4) ? |(addr_i >> 4) : 1'b0;
  wire       wr_mode  = wr_i && !addr_hi && (reg_idx == REG_MODE);
  wire       wr_kfrm  = wr_i && !addr_hi && (reg_idx == REG_KFRM);
  wire       wr_did   = wr_i && !addr_hi && (reg_idx == REG_DID);
  wire       wr_ctrl  = wr_i && !addr_hi && (reg_idx == REG_CTRL);

  // ==========================================================
  // derived mode view
  wire       mode_ok  = prm_if.p.valid;
  wire       is_des   = prm_if.p.des;
  wire       is_64b   = prm_if.p.enc64;
  wire [1:0] insel    = ctrl_reg[CTRL_SEL_LSB +: 2];
  wire       link_en  = ctrl_reg[CTRL_LINK];
  // both inputs only count when the mode is single channel
  wire       dual_in  = mode_ok && is_des && (insel == INSEL_BOTH);
  // the K field only matters under 8b/10b coding
  wire [8:0] k_eff    = is_64b ? 9'h000
                               : {1'b0, frames_per_multiframe_minus_one} + 9'h001;
  wire       bypass   = prm_if.p.rate_x8 < RATE_X8_BYPASS;

  // ==========================================================
  // sequence control
  wire idle       = (state == ST_IDLE);
  wire last_oct   = (idx_cnt == OCT_CHK);
  wire last_lane  = (lane_cnt == prm_if.p.lm1);
  // refused under 64b/66b, a bad mode or a disabled link
  wire can_start  = mode_ok && link_en && !is_64b;
  wire go         = idle && ilas_start_i && can_start;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (last_oct && last_lane) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // state and octet counters; every lane gets all fourteen octets
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      idx_cnt  <= OCT_DID;
      lane_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (idle) begin
        idx_cnt  <= OCT_DID;
        lane_cnt <= 3'h0;
      end else if (last_oct) begin
        idx_cnt  <= OCT_DID;
        lane_cnt <= lane_cnt + 3'h1;
      end else begin
        idx_cnt <= idx_cnt + 4'h1;
      end
    end
  end

  // tags trail the assembler by its one register stage
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pipe_valid   <= 1'b0;
      pipe_last    <= 1'b0;
      pipe_lane    <= 3'h0;
    end else begin
      pipe_valid   <= !idle;
      pipe_last    <= !idle && last_oct;
      pipe_lane    <= lane_cnt;
    end
  end

  assign ilas_octet_o = fmt_octet; // straight from the assembler flop
  assign ilas_valid_o = pipe_valid;
  assign ilas_last_o  = pipe_last;
  assign ilas_lane_o  = pipe_lane;

  // ==========================================================
  // writable registers
  // changes made mid-sequence take effect on the next octet, a mode change one octet later; software
  // should hold the configuration while a sequence is running
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      link_mode_select                <= MODE_RST;
      frames_per_multiframe_minus_one <= KFRM_RST;
      did_reg                         <= DID_RST;
      ctrl_reg                        <= CTRL_RST;
    end else begin
      if (wr_mode) begin
        link_mode_select <= wdata_i[4:0];
      end
      if (wr_kfrm) begin
        frames_per_multiframe_minus_one <= wdata_i;
      end
      if (wr_did) begin
        did_reg <= wdata_i;
      end
      if (wr_ctrl) begin
        ctrl_reg <= {4'h0, wdata_i[3:0]};
      end
    end
  end

  // ==========================================================
  // read-back mux; unmapped words read zero
  always_comb begin
    next_rdata = 8'h00;
    if (!addr_hi) begin
      unique case (reg_idx)
        REG_MODE:   next_rdata = {3'h0, link_mode_select};
        REG_KFRM:   next_rdata = frames_per_multiframe_minus_one;
        REG_DID:    next_rdata = did_reg;
        REG_CTRL:   next_rdata = ctrl_reg;
        REG_STATUS: next_rdata = {3'h0, !idle, is_64b, dual_in, is_des, mode_ok};
        REG_PARAM0: next_rdata = {2'h0, prm_if.p.fm1, prm_if.p.lm1};
        REG_PARAM1: next_rdata = {prm_if.p.npm1, prm_if.p.nm1};
        REG_CHKSUM: next_rdata = fmt_chk;
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00; // data stand only in the cycle after the strobe
    end
  end

  // ==========================================================
  // registered configuration outputs toward sampling and serializer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      link_en_o            <= 1'b0;
      scr_en_o             <= 1'b0;
      des_o                <= 1'b0;
      dual_input_o         <= 1'b0;
      dsp_single_o         <= 1'b0;
      adc_b_invert_phase_o <= 1'b0;
      samp_rate_mult_o     <= RATE_DUAL;
      ain_sel_o            <= INSEL_A;
      enc64_o              <= 1'b0;
      lanes_m1_o           <= 3'h0;
      rate_x8_o            <= 6'h00;
      pll_bypass_o         <= 1'b0;
      frames_per_mf_o      <= 9'h000;
      emb_count_o          <= EMB_FIXED;
    end else begin
      link_en_o            <= link_en && mode_ok;
      scr_en_o             <= ctrl_reg[CTRL_SCR];
      des_o                <= mode_ok && is_des;
      dual_input_o         <= dual_in;
      // the datapath never sees the dual-input case as different
      dsp_single_o         <= mode_ok && is_des;
      // second core samples on the opposite clock edge
      adc_b_invert_phase_o <= mode_ok && is_des;
      samp_rate_mult_o     <= (mode_ok && is_des) ? RATE_DES : RATE_DUAL;
      ain_sel_o            <= insel;
      enc64_o              <= is_64b;
      lanes_m1_o           <= prm_if.p.lm1;
      rate_x8_o            <= prm_if.p.rate_x8;
      pll_bypass_o         <= bypass;
      frames_per_mf_o      <= k_eff;
      emb_count_o          <= EMB_FIXED;
    end
  end

endmodule // jmip_top

// [tb/jmip_rx_model.sv]
// receiving-side model that captures the alignment octets in arrival order
`timescale 1ns/1ps
module jmip_rx_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] octet_i,
  input  wire logic       valid_i,
  input  wire logic [2:0] lane_i
);
  logic [7:0] oct [112];
  logic [2:0] ln  [112];
  int         n;
  int         idx;
  logic       valid_q;

  // a fresh stream starts filling from slot zero again
  assign idx = valid_q ? n : 0;

  // ==========================================================
  // capture: octets stored raw; the converter count is kept as a packing field
  // only, never taken as the number of channels
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      n       <= 0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_i;
      if (valid_i && idx < 112) begin
        n        <= idx + 1;
        oct[idx] <= octet_i;
        ln[idx]  <= lane_i;
      end
    end
  end
endmodule // jmip_rx_model

// [tb/jmip_top_assertions.sv]
// port-level checks on the link mode and alignment-parameter block
`timescale 1ns/1ps
module jmip_top_assertions
  import jmip_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ilas_start_i,
  input  wire logic [7:0] ilas_octet_o,
  input  wire logic       ilas_valid_o,
  input  wire logic [2:0] ilas_lane_o,
  input  wire logic       ilas_last_o,
  input  wire logic       link_en_o,
  input  wire logic       scr_en_o,
  input  wire logic       des_o,
  input  wire logic       dual_input_o,
  input  wire logic       dsp_single_o,
  input  wire logic       adc_b_invert_phase_o,
  input  wire logic [1:0] samp_rate_mult_o,
  input  wire logic [1:0] ain_sel_o,
  input  wire logic [5:0] rate_x8_o,
  input  wire logic       pll_bypass_o,
  input  wire logic [3:0] emb_count_o
);
  logic [3:0] pos;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // octet position inside one lane block, restarted by the last octet
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)
      pos <= 4'h0;
    else if (!ilas_valid_o || ilas_last_o)
      pos <= 4'h0;
    else
      pos <= pos + 4'h1;
  end

  chk_samp_rate: assert property (samp_rate_mult_o == (des_o ? 2'h2 : 2'h1))
    else $error("sample rate factor wrong");
  chk_single_path: assert property (dsp_single_o == des_o && adc_b_invert_phase_o == des_o)
    else $error("single-channel path mismatch");
  chk_dual_cond: assert property (dual_input_o |-> des_o && ain_sel_o == INSEL_BOTH)
    else $error("dual input without its conditions");
  chk_pll_bypass: assert property (rate_x8_o != 6'h00 && $stable(rate_x8_o)
    |-> pll_bypass_o == (rate_x8_o < RATE_X8_BYPASS))
    else $error("pll bypass does not follow rate");
  chk_emb_one: assert property (emb_count_o == 4'h1)
    else $error("multiblock count not one");
  chk_start_lat: assert property ($rose(ilas_valid_o) |-> $past(ilas_start_i, 2) && link_en_o)
    else $error("stream began without a start");
  chk_first_last: assert property ($rose(ilas_valid_o) |-> ##13 ilas_last_o)
    else $error("first lane block not 14 octets");
  chk_last_pos: assert property (ilas_valid_o |-> ilas_last_o == (pos == 4'hd))
    else $error("last flag off its octet");
  chk_zero_fields: assert property (ilas_valid_o
    && (pos == 4'h1 || (pos >= 4'ha && pos <= 4'hc)) |-> ilas_octet_o == 8'h00)
    else $error("fixed zero octet not zero");
  chk_cs_zero: assert property (ilas_valid_o && pos == 4'h7 |-> ilas_octet_o[7:5] == 3'h0)
    else $error("control bits field not zero");
  chk_versions: assert property (ilas_valid_o && (pos == 4'h8 || pos == 4'h9)
    |-> ilas_octet_o[7:5] == 3'h1)
    else $error("version field not one");
  chk_scr_field: assert property (ilas_valid_o && pos == 4'h3 |-> ilas_octet_o[7] == scr_en_o)
    else $error("scrambler field mismatch");
  chk_lane_id: assert property (ilas_valid_o && pos == 4'h2 |-> ilas_octet_o == {5'h00, ilas_lane_o})
    else $error("lane id octet mismatch");
endmodule // jmip_top_assertions

bind jmip_top jmip_top_assertions u_chk (
  .mclk_i, .rst_i, .ilas_start_i, .ilas_octet_o, .ilas_valid_o, .ilas_lane_o, .ilas_last_o,
  .link_en_o, .scr_en_o, .des_o, .dual_input_o, .dsp_single_o, .adc_b_invert_phase_o,
  .samp_rate_mult_o, .ain_sel_o, .rate_x8_o, .pll_bypass_o, .emb_count_o
);

// [tb/tb_jmip_top.sv]
// self-checking bench for the link mode and alignment-parameter block
`timescale 1ns/1ps
module tb_jmip_top;
  import jmip_pkg::*;
  logic       mclk_i       = 1'b0;
  logic       rst_i        = 1'b1;
  logic [3:0] addr_i       = 4'h0;
  logic [7:0] wdata_i      = 8'h00;
  logic       wr_i         = 1'b0;
  logic       rd_i         = 1'b0;
  logic       ilas_start_i = 1'b0;
  logic       ilas_valid_o, ilas_last_o, link_en_o, scr_en_o, des_o, dual_input_o;
  logic       dsp_single_o, adc_b_invert_phase_o, enc64_o, pll_bypass_o;
  logic [1:0] samp_rate_mult_o, ain_sel_o;
  logic [2:0] ilas_lane_o, lanes_m1_o;
  logic [3:0] emb_count_o;
  logic [5:0] rate_x8_o;
  logic [7:0] rdata_o, ilas_octet_o;
  logic [8:0] frames_per_mf_o;
  int         err_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         cl, cf, cm, csp, cn, cnp;
  logic [7:0] cdid, ckm;
  logic       cscr;

  always #12.5 mclk_i = ~mclk_i;

  jmip_top dut (
    .mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ilas_start_i, .ilas_octet_o,
    .ilas_valid_o, .ilas_lane_o, .ilas_last_o, .link_en_o, .scr_en_o, .des_o, .dual_input_o,
    .dsp_single_o, .adc_b_invert_phase_o, .samp_rate_mult_o, .ain_sel_o, .enc64_o,
    .lanes_m1_o, .rate_x8_o, .pll_bypass_o, .frames_per_mf_o, .emb_count_o
  );
  jmip_rx_model rx (
    .mclk_i, .rst_i, .octet_i(ilas_octet_o), .valid_i(ilas_valid_o), .lane_i(ilas_lane_o)
  );

  // ==========================================================
  // verdict and the guard against a hung run
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // register port cycles and comparison
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;  // data stand only in this one cycle
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmp(16'(d), 16'(e));
  endtask
  task automatic pulse();
    @(posedge mclk_i);
    ilas_start_i <= 1'b1;
    @(posedge mclk_i);
    ilas_start_i <= 1'b0;
  endtask

  // ==========================================================
  // expected octet i of lane ln; checksum sums minus-one counts plus both versions
  function automatic logic [7:0] exp_oct(input int ln, input int i);
    logic [7:0] e [14];
    e = '{cdid, 8'h00, 8'(ln), {cscr, 4'h0, 3'(cl - 1)}, 8'(cf - 1), ckm, 8'(cm - 1),
          8'(cn - 1), 8'(32 + cnp - 1), 8'(32 + csp - 1), 8'h00, 8'h00, 8'h00,
          8'(cdid + ln + cscr + cl + cf + ckm + cm + cn + cnp + csp - 4)};
    return e[i];
  endfunction

  // mode, lanes, octets, converters, samples, bits, bits with tail, rate x 8, single
  task automatic set_mode(input int md, l, f, m, s, n, np, r8, ds);
    wr(REG_MODE, 8'(md));
    repeat (2) @(posedge mclk_i);
    #1;
    {cl, cf, cm, csp, cn, cnp} = {l, f, m, s, n, np};
    cmp(des_o, 16'(ds));
    cmp(samp_rate_mult_o, ds ? 16'h2 : 16'h1);
    cmp(dsp_single_o, 16'(ds));
    cmp(lanes_m1_o, 16'(l - 1));
    cmp(rate_x8_o, 16'(r8));
    cmp(pll_bypass_o, 16'(r8 < 16));
    chk_rd(REG_PARAM0, 8'(((f - 1) << 3) | (l - 1)));
    chk_rd(REG_PARAM1, 8'(((np - 1) << 4) | (n - 1)));
  endtask

  task automatic run_ilas(input logic [7:0] did, input logic [7:0] kfm, input logic scr);
    int t;
    {cdid, ckm, cscr} = {did, kfm, scr};
    wr(REG_DID, did);
    wr(REG_KFRM, kfm);
    wr(REG_CTRL, {5'h01, INSEL_A, scr});
    @(posedge mclk_i);
    #1;
    cmp(frames_per_mf_o, 16'(kfm) + 16'h1);
    cmp(scr_en_o, 16'(scr));
    chk_rd(REG_CHKSUM, exp_oct(0, 13));
    pulse();
    t = 0;
    while (ilas_valid_o !== 1'b1 && t < 10) begin
      @(posedge mclk_i);
      #1;
      t++;
    end
    pulse();  // a start while busy must be ignored
    repeat (14 * cl + 4) @(posedge mclk_i);
    #1;
    cmp(ilas_valid_o, 16'h0);
    cmp(16'(rx.n), 16'(14 * cl));
    for (int l = 0; l < cl; l++) begin
      cmp(rx.ln[14 * l], 16'(l));
      for (int i = 0; i < 14; i++)
        cmp(rx.oct[14 * l + i], exp_oct(l, i));
    end
  endtask

  task automatic no_ilas();
    pulse();
    repeat (6) @(posedge mclk_i);
    #1;
    cmp(ilas_valid_o, 16'h0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk_rd(REG_MODE, 8'(MODE_RST));
    chk_rd(REG_KFRM, KFRM_RST);
    chk_rd(REG_DID, DID_RST);
    chk_rd(REG_CTRL, CTRL_RST);
    chk_rd(4'hf, 8'h00);
    cmp(frames_per_mf_o, 16'h0020);
    cmp(emb_count_o, 16'h0001);
    cmp(enc64_o, 16'h0000);
    wr(REG_STATUS, 8'hff);
    wr(REG_CTRL, 8'hff);
    chk_rd(REG_CTRL, 8'h0f);
    set_mode(0, 4, 8, 4, 5, 12, 12, 32, 1);
    wr(REG_CTRL, 8'h0c);
    chk_rd(REG_STATUS, 8'h07);
    cmp(dual_input_o, 16'h1);
    cmp(ain_sel_o, 16'(INSEL_BOTH));
    set_mode(2, 4, 8, 4, 5, 12, 12, 32, 0);
    chk_rd(REG_STATUS, 8'h01);
    cmp(dual_input_o, 16'h0);
    set_mode(6, 8, 1, 1, 8, 8, 8, 10, 1);
    set_mode(23, 1, 2, 1, 1, 15, 16, 40, 1);
    set_mode(13, 1, 4, 2, 1, 15, 16, 40, 0);
    run_ilas(8'h5a, 8'h07, 1'b1);
    set_mode(0, 4, 8, 4, 5, 12, 12, 32, 1);
    run_ilas(8'hc3, 8'hff, 1'b0);
    wr(REG_MODE, 8'h04);
    repeat (2) @(posedge mclk_i);
    #1;
    cmp(link_en_o, 16'h0);
    chk_rd(REG_STATUS, 8'h00);
    no_ilas();
    set_mode(13, 1, 4, 2, 1, 15, 16, 40, 0);
    wr(REG_CTRL, 8'h01);
    no_ilas();
    end_of_test();
  end
endmodule // tb_jmip_top
